// ---- core/hss_cfg_consts.svh ----
`ifndef HSS_CFG_CONSTS_SVH
`define HSS_CFG_CONSTS_SVH

// Message layout
`define MSG_BITS          16
`define MSG_CHAN_HI       14
`define MSG_CHAN_LO       13
`define MSG_ADDR_HI       14
`define MSG_ADDR_LO       10
`define MSG_CODE_HI       12
`define MSG_CODE_LO       10

// Register select codes
`define CODE_SWITCHING    3'h2
`define CODE_FAULT        3'h3
`define CODE_OVERCURRENT  3'h4
`define ADDR_GLOBAL       5'h05
`define ADDR_CALIBRATION  5'h07

// Switching register fields
`define SW_DIR_DIS        5
`define SW_SLEW_HI        4
`define SW_SLEW_LO        3
`define SW_DELAY_HI       2
`define SW_DELAY_LO       0

// Fault register fields
`define FLT_RETRY_UNLIM   6
`define FLT_RETRY_DIS     5
`define FLT_OS_DIS        4
`define FLT_OLON_DIS      3
`define FLT_OLOFF_DIS     2
`define FLT_OLLED         1
`define FLT_RATIO         0

// Over-current register fields
`define OC_COOL_HI        7
`define OC_COOL_LO        6
`define OC_INRUSH_HI      5
`define OC_INRUSH_LO      4
`define OC_ALT_HIGH       3
`define OC_STEADY_HI      2
`define OC_STEADY_LO      1
`define OC_MODE           0

// Global register fields
`define GL_VDD_FAIL_EN    8
`define GL_PWM_EN         7
`define GL_CLOCK_SEL      6
`define GL_TEMP_EN        5
`define GL_CURRENT_FEEDBACK_ENABLE        4
`define GL_ANALOG_SENSE_PIN_HI        3
`define GL_ANALOG_SENSE_PIN_LO        2
`define GL_OVERVOLTAGE_PROTECT_DISABLE         0

// Reset values
`define RST_CFG9          9'h000
`define RST_BIT_COUNT     16'h0000
`define RST_WORD          16'h0000

`endif

// ---- core/hss_cfg_pkg.sv ----
package hss_cfg_pkg;

   typedef enum logic [1:0] {
      SLEW_MEDIUM = 2'b00,
      SLEW_LOW    = 2'b01,
      SLEW_HIGH   = 2'b10
   } slew_t;

   typedef enum logic [1:0] {
      OLON_BULB     = 2'b00,
      OLON_LED      = 2'b01,
      OLON_DISABLED = 2'b10
   } olon_mode_t;

   typedef enum logic [1:0] {
      SENSE_TRISTATE = 2'b00,
      SENSE_CURRENT  = 2'b01,
      SENSE_TEMP     = 2'b10
   } sense_src_t;

   typedef enum logic [1:0] {
      PWM_OFF       = 2'b00,
      PWM_EXT_CLOCK = 2'b01,
      PWM_INT_CLOCK = 2'b10
   } pwm_clk_t;

   typedef struct packed {
      logic       dir_dis;
      logic [1:0] slew;
      logic [2:0] delay;
      logic       retry_unlimited;
      logic       retry_dis;
      logic       os_dis;
      logic       olon_dis;
      logic       oloff_dis;
      logic       olled;
      logic       ratio_high;
      logic [1:0] cooling;
      logic [1:0] inrush;
      logic       alt_high;
      logic [1:0] steady;
      logic       oc_mode;
   } chan_cfg_t;

   typedef struct packed {
      logic       vdd_fail_en;
      logic       pwm_en;
      logic       clock_sel;
      logic       temp_en;
      logic       current_feedback_enable;
      logic [1:0] analog_sense_pin_sel;
      logic       overvoltage_protect_disable;
   } global_cfg_t;

endpackage

// ---- core/output_config_register_bank.sv ----
// Overview of operation
// - Per-output writes touch only the output chosen by message bits 14:13.
// - Direct-input disable clear lets input pin drive output; set leaves on bit only.
// - Slew code 00 medium, 01 low, 10 high; 11 unused.
// - Delay bits give PWM clock edges of delay, only while PWM enabled.
// - Fault bit 6 set disables the autoretry counter for that output.
// - Fault bit 5 set disables automatic retry for that output.
// - Fault bit 4 set disables short-to-battery protection for that output.
// - On open-load: bit 3 disables; else bit 1 picks bulb or LED.
// - Fault bit 2 set disables off-state open-load detection.
// - Fault bit 0 picks low or high current-sense ratio.
// - Cooling curve code 00 medium, 01 slow, 10 fast, 11 medium.
// - Inrush curve code 00 slow, 01 fast, 10 medium, 11 very slow.
// - Over-current bit 3 swaps in second high threshold during initial window.
// - Steady limit code 00 two, 01 three, 10 four, 11 one.
// - Over-current bit 0: inrush only, or inrush plus cooling management.
// - Global bit 8 enables logic-supply failure detector.
// - Global bit 7 enables PWM; outputs follow duty registers, inputs ignored.
// - Global bit 6 picks external or internal PWM clock when PWM enabled.
// - Global bits 5:4 pick sense pin source: current, temperature or tristate.
// - Global bits 3:2 pick which output current is copied.
// - Global bit 0 set disables over-voltage protection.
// - Codes: xx010 switching, xx011 fault, xx100 over-current, 00101 global, 00111 calibration.
// - Each output's on bit turns it on while PWM is disabled.
// - Only messages a nonzero multiple of 16 bits long update registers.
`timescale 1ns/100ps
`default_nettype none
`include "hss_cfg_consts.svh"

module output_config_register_bank
   import hss_cfg_pkg::*;
(
   input  wire logic                 i_clk,
   input  wire logic                 i_resetn,
   input  wire logic                 i_ce,
   input  wire logic                 i_spi_sclk,
   input  wire logic                 i_spi_cs_n,
   input  wire logic                 i_spi_si,
   input  wire logic [3:0]           i_direct_in,
   input  wire logic [3:0]           i_on_bit,
   input  wire logic [3:0]           i_pwm_drive,
   output chan_cfg_t [3:0]           o_chan_cfg,
   output global_cfg_t               o_global_cfg,
   output slew_t [3:0]               o_slew,
   output olon_mode_t [3:0]          o_olon_mode,
   output logic [3:0][2:0]           o_delay_eff,
   output logic [3:0]                o_out_on,
   output sense_src_t                o_sense_src,
   output pwm_clk_t                  o_pwm_clk,
   output logic                      o_cal_pulse,
   output logic                      o_msg_rejected
);

   // Link domain: shifts bits and counts them, never cleared between frames
   logic [15:0] shift_word;
   logic [15:0] bit_count;

   always_ff @(posedge i_spi_sclk or negedge i_resetn) begin
      if (!i_resetn) begin
         shift_word <= `RST_WORD;
      end else if (!i_spi_cs_n) begin
         shift_word <= {shift_word[14:0], i_spi_si};
      end
   end

   always_ff @(posedge i_spi_sclk or negedge i_resetn) begin
      if (!i_resetn) begin
         bit_count <= `RST_BIT_COUNT;
      end else if (!i_spi_cs_n) begin
         bit_count <= bit_count + 16'h0001;
      end
   end

   // Core domain: chip select level synchronised, word and count follow in step.
   // Word and count are static while select is high, so sampling them in
   // step with the select synchroniser is safe.
   logic        cs_s1;
   logic        cs_s2;
   logic        cs_d;
   logic [15:0] word_s1;
   logic [15:0] word_s2;
   logic [15:0] cnt_s1;
   logic [15:0] cnt_s2;
   logic [15:0] last_count;
   logic [3:0]  din_s1;
   logic [3:0]  din_s2;

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cs_s1 <= 1'b1;
         cs_s2 <= 1'b1;
         cs_d  <= 1'b1;
      end else if (i_ce) begin
         cs_s1 <= i_spi_cs_n;
         cs_s2 <= cs_s1;
         cs_d  <= cs_s2;
      end
   end

   // Mid-frame samples may be torn; only the copy taken after the select
   // rise is ever used, and by then the link side has stopped shifting.
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         word_s1 <= `RST_WORD;
         word_s2 <= `RST_WORD;
      end else if (i_ce) begin
         word_s1 <= shift_word;
         word_s2 <= word_s1;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cnt_s1 <= `RST_BIT_COUNT;
         cnt_s2 <= `RST_BIT_COUNT;
      end else if (i_ce) begin
         cnt_s1 <= bit_count;
         cnt_s2 <= cnt_s1;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         din_s1 <= 4'h0;
         din_s2 <= 4'h0;
      end else if (i_ce) begin
         din_s1 <= i_direct_in;
         din_s2 <= din_s1;
      end
   end

   logic        frame_end;
   logic [15:0] frame_len;
   logic        frame_ok;
   logic [4:0]  msg_addr;
   logic [2:0]  msg_code;
   logic [1:0]  msg_chan;
   logic [8:0]  msg_data;

   // A select pulse with no clocks gives length zero and is refused too
   assign frame_end = cs_s2 & ~cs_d;
   assign frame_len = cnt_s2 - last_count;
   assign frame_ok  = (frame_len != 16'h0000) && (frame_len[3:0] == 4'h0);
   assign msg_addr  = word_s2[`MSG_ADDR_HI:`MSG_ADDR_LO];
   assign msg_code  = word_s2[`MSG_CODE_HI:`MSG_CODE_LO];
   assign msg_chan  = word_s2[`MSG_CHAN_HI:`MSG_CHAN_LO];
   assign msg_data  = word_s2[8:0];

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         last_count <= `RST_BIT_COUNT;
      end else if (i_ce && frame_end) begin
         last_count <= cnt_s2;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_msg_rejected <= 1'b0;
      end else if (i_ce) begin
         o_msg_rejected <= frame_end & ~frame_ok;
      end
   end

   // Calibration itself lives elsewhere; here the frame is only flagged
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_cal_pulse <= 1'b0;
      end else if (i_ce) begin
         o_cal_pulse <= frame_end & frame_ok & (msg_addr == `ADDR_CALIBRATION);
      end
   end

   // Per-output registers, one set per channel, and the single global register
   logic [3:0][8:0] sw_reg;
   logic [3:0][8:0] flt_reg;
   logic [3:0][8:0] oc_reg;
   logic [8:0]      gl_reg;
   logic            wr_en;

   assign wr_en = i_ce & frame_end & frame_ok;

   // Other codes (duty, status, global, calibration) leave all channels alone
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         for (int c = 0; c < 4; c++) begin
            sw_reg[c] <= `RST_CFG9;
         end
      end else if (wr_en && msg_code == `CODE_SWITCHING) begin
         sw_reg[msg_chan] <= msg_data;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         for (int c = 0; c < 4; c++) begin
            flt_reg[c] <= `RST_CFG9;
         end
      end else if (wr_en && msg_code == `CODE_FAULT) begin
         flt_reg[msg_chan] <= msg_data;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         for (int c = 0; c < 4; c++) begin
            oc_reg[c] <= `RST_CFG9;
         end
      end else if (wr_en && msg_code == `CODE_OVERCURRENT) begin
         oc_reg[msg_chan] <= msg_data;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         gl_reg <= `RST_CFG9;
      end else if (wr_en && msg_addr == `ADDR_GLOBAL) begin
         gl_reg <= msg_data;
      end
   end

   // Unused slew code falls back to the default speed
   function automatic slew_t slew_decode(input logic [1:0] code);
      unique case (code)
         2'b01:   slew_decode = SLEW_LOW;
         2'b10:   slew_decode = SLEW_HIGH;
         default: slew_decode = SLEW_MEDIUM;
      endcase
   endfunction

   function automatic olon_mode_t olon_decode(input logic dis, input logic led);
      if (dis) begin
         olon_decode = OLON_DISABLED;
      end else begin
         olon_decode = led ? OLON_LED : OLON_BULB;
      end
   endfunction

   chan_cfg_t [3:0] next_chan_cfg;
   global_cfg_t     next_global_cfg;

   always_comb begin
      for (int c = 0; c < 4; c++) begin
         next_chan_cfg[c].dir_dis         = sw_reg[c][`SW_DIR_DIS];
         next_chan_cfg[c].slew            = sw_reg[c][`SW_SLEW_HI:`SW_SLEW_LO];
         next_chan_cfg[c].delay           = sw_reg[c][`SW_DELAY_HI:`SW_DELAY_LO];
         next_chan_cfg[c].retry_unlimited = flt_reg[c][`FLT_RETRY_UNLIM];
         next_chan_cfg[c].retry_dis       = flt_reg[c][`FLT_RETRY_DIS];
         next_chan_cfg[c].os_dis          = flt_reg[c][`FLT_OS_DIS];
         next_chan_cfg[c].olon_dis        = flt_reg[c][`FLT_OLON_DIS];
         next_chan_cfg[c].oloff_dis       = flt_reg[c][`FLT_OLOFF_DIS];
         next_chan_cfg[c].olled           = flt_reg[c][`FLT_OLLED];
         next_chan_cfg[c].ratio_high      = flt_reg[c][`FLT_RATIO];
         next_chan_cfg[c].cooling         = oc_reg[c][`OC_COOL_HI:`OC_COOL_LO];
         next_chan_cfg[c].inrush          = oc_reg[c][`OC_INRUSH_HI:`OC_INRUSH_LO];
         next_chan_cfg[c].alt_high        = oc_reg[c][`OC_ALT_HIGH];
         next_chan_cfg[c].steady          = oc_reg[c][`OC_STEADY_HI:`OC_STEADY_LO];
         next_chan_cfg[c].oc_mode         = oc_reg[c][`OC_MODE];
      end
      next_global_cfg.vdd_fail_en = gl_reg[`GL_VDD_FAIL_EN];
      next_global_cfg.pwm_en      = gl_reg[`GL_PWM_EN];
      next_global_cfg.clock_sel   = gl_reg[`GL_CLOCK_SEL];
      next_global_cfg.temp_en     = gl_reg[`GL_TEMP_EN];
      next_global_cfg.current_feedback_enable     = gl_reg[`GL_CURRENT_FEEDBACK_ENABLE];
      next_global_cfg.analog_sense_pin_sel    = gl_reg[`GL_ANALOG_SENSE_PIN_HI:`GL_ANALOG_SENSE_PIN_LO];
      next_global_cfg.overvoltage_protect_disable      = gl_reg[`GL_OVERVOLTAGE_PROTECT_DISABLE];
   end

   // Raw fields and decoded outputs all load at one edge, so they never disagree
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_chan_cfg <= '0;
      end else if (i_ce) begin
         o_chan_cfg <= next_chan_cfg;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_global_cfg <= '0;
      end else if (i_ce) begin
         o_global_cfg <= next_global_cfg;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         for (int c = 0; c < 4; c++) begin
            o_slew[c] <= SLEW_MEDIUM;
         end
      end else if (i_ce) begin
         for (int c = 0; c < 4; c++) begin
            o_slew[c] <= slew_decode(next_chan_cfg[c].slew);
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         for (int c = 0; c < 4; c++) begin
            o_olon_mode[c] <= OLON_BULB;
         end
      end else if (i_ce) begin
         for (int c = 0; c < 4; c++) begin
            o_olon_mode[c] <= olon_decode(next_chan_cfg[c].olon_dis,
                                          next_chan_cfg[c].olled);
         end
      end
   end

   // Stored delay is kept while PWM is off, only its effect is masked
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_delay_eff <= '0;
      end else if (i_ce) begin
         for (int c = 0; c < 4; c++) begin
            o_delay_eff[c] <= next_global_cfg.pwm_en ? next_chan_cfg[c].delay : 3'h0;
         end
      end
   end

   // Output drive: PWM overrides everything, else on bit, ORed with direct pin unless direct input is disabled
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_out_on <= 4'h0;
      end else if (i_ce) begin
         for (int c = 0; c < 4; c++) begin
            if (next_global_cfg.pwm_en) begin
               o_out_on[c] <= i_pwm_drive[c];
            end else if (next_chan_cfg[c].dir_dis) begin
               o_out_on[c] <= i_on_bit[c];
            end else begin
               o_out_on[c] <= din_s2[c] | i_on_bit[c];
            end
         end
      end
   end

   // Current copy wins when both sense sources are asked for
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_sense_src <= SENSE_TRISTATE;
      end else if (i_ce) begin
         if (next_global_cfg.current_feedback_enable) begin
            o_sense_src <= SENSE_CURRENT;
         end else if (next_global_cfg.temp_en) begin
            o_sense_src <= SENSE_TEMP;
         end else begin
            o_sense_src <= SENSE_TRISTATE;
         end
      end
   end

   // Clock select is meaningless with PWM off, so it reads as off then
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_pwm_clk <= PWM_OFF;
      end else if (i_ce) begin
         if (!next_global_cfg.pwm_en) begin
            o_pwm_clk <= PWM_OFF;
         end else begin
            o_pwm_clk <= next_global_cfg.clock_sel ? PWM_INT_CLOCK : PWM_EXT_CLOCK;
         end
      end
   end

endmodule // output_config_register_bank
`default_nettype wire

// ---- tb/mcu_link_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module mcu_link_model (
   output logic o_sclk,
   output logic o_cs_n,
   output logic o_si
);
   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_si   = 1'b0;
   end

   // Any length is sent so that the device's length check can be provoked
   task automatic send(input logic [31:0] word, input int n);
      o_cs_n = 1'b0;
      if (n == 0) #250;  // Empty frame must still span two core clock edges
      for (int b = n - 1; b >= 0; b--) begin
         o_si = word[b];  // MSB first; output select 14:13, code 12:10
         #16 o_sclk = 1'b1;
         #16 o_sclk = 1'b0;
      end
      o_si = ~o_si;  // Released line must not keep showing the last bit
      #16 o_cs_n = 1'b1;
      #800;  // Long cs-high gap also lets the frame reach the outputs
   endtask
endmodule // mcu_link_model

`default_nettype wire

// ---- tb/output_config_register_bank_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none

module output_config_register_bank_monitor
   import hss_cfg_pkg::*;
(
   input wire logic             i_clk,
   input wire logic             i_resetn,
   input wire logic [3:0]       i_pwm_drive,
   input wire logic [3:0]       i_direct_in,
   input wire logic [3:0]       i_on_bit,
   input wire chan_cfg_t [3:0]  o_chan_cfg,
   input wire global_cfg_t      o_global_cfg,
   input wire slew_t [3:0]      o_slew,
   input wire olon_mode_t [3:0] o_olon_mode,
   input wire logic [3:0][2:0]  o_delay_eff,
   input wire logic [3:0]       o_out_on,
   input wire sense_src_t       o_sense_src,
   input wire pwm_clk_t         o_pwm_clk,
   input wire logic             o_cal_pulse,
   input wire logic             o_msg_rejected
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   // Pin history before reset release is meaningless for the drive check
   logic [2:0] since_rst;

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         since_rst <= 3'h0;
      end else if (since_rst != 3'h4) begin
         since_rst <= since_rst + 3'h1;
      end
   end

   sequence s_cfg_held;
      $stable(o_chan_cfg) && $stable(o_global_cfg);
   endsequence

   sequence s_pwm_settled;
      o_global_cfg.pwm_en [*3];
   endsequence

   for (genvar c = 0; c < 4; c++) begin : g_chan
      a_slew_decode: assert property (
         o_slew[c] == (o_chan_cfg[c].slew == 2'b11 ? SLEW_MEDIUM : slew_t'(o_chan_cfg[c].slew)))
         else $error("slew decode wrong");
      a_olon_decode: assert property (
         o_olon_mode[c] == (o_chan_cfg[c].olon_dis ? OLON_DISABLED :
                            o_chan_cfg[c].olled ? OLON_LED : OLON_BULB))
         else $error("open-load mode decode wrong");
      a_delay_gated: assert property (
         o_delay_eff[c] == (o_global_cfg.pwm_en ? o_chan_cfg[c].delay : 3'h0))
         else $error("delay not gated by pwm enable");
      a_direct_drive: assert property (
         since_rst == 3'h4 && !o_global_cfg.pwm_en |->
            o_out_on[c] == (o_chan_cfg[c].dir_dis ? $past(i_on_bit[c]) :
                            $past(i_on_bit[c]) | $past(i_direct_in[c], 3)))
         else $error("output drive wrong without pwm");
   end

   a_sense_source: assert property (
      o_sense_src == (o_global_cfg.current_feedback_enable ? SENSE_CURRENT :
                      o_global_cfg.temp_en ? SENSE_TEMP : SENSE_TRISTATE))
      else $error("sense source decode wrong");
   a_pwm_clock: assert property (
      o_pwm_clk == (!o_global_cfg.pwm_en ? PWM_OFF :
                    o_global_cfg.clock_sel ? PWM_INT_CLOCK : PWM_EXT_CLOCK))
      else $error("pwm clock decode wrong");
   a_reject_no_write: assert property (
      o_msg_rejected |-> s_cfg_held ##1 !o_msg_rejected)
      else $error("rejected frame changed config");
   a_cal_no_write: assert property (
      o_cal_pulse |-> s_cfg_held and !o_msg_rejected)
      else $error("calibration frame changed config");
   a_pwm_drives_out: assert property (
      s_pwm_settled |-> o_out_on == $past(i_pwm_drive))
      else $error("outputs not following pwm drive");
endmodule // output_config_register_bank_monitor

`default_nettype wire

// ---- tb/output_config_register_bank_test.sv ----
`timescale 1ns/100ps
`default_nettype none

module output_config_register_bank_test;
   import hss_cfg_pkg::*;

   typedef struct packed {
      chan_cfg_t [3:0] cfg;
      global_cfg_t     g;
      logic            rej;
      logic            cal;
   } exp_t;

   logic            i_clk;
   logic            i_resetn;
   logic            sclk;
   logic            cs_n;
   logic            si;
   logic [3:0]      direct_in = 4'h0;
   logic [3:0]      on_bit    = 4'h0;
   logic [3:0]      pwm_drive = 4'h0;
   chan_cfg_t [3:0] chan_cfg;
   global_cfg_t     glob;
   logic            rej;
   logic            cal;
   logic [31:0]     rnd = 32'h0000_1025;
   int              n_errors = 0;
   int              samples_checked = 0;
   exp_t            cur = '0;
   exp_t            seen;
   exp_t            prev;
   exp_t            notes[$];

   output_config_register_bank i_output_config_register_bank (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_ce(1'b1), .i_spi_sclk(sclk), .i_spi_cs_n(cs_n),
      .i_spi_si(si), .i_direct_in(direct_in), .i_on_bit(on_bit), .i_pwm_drive(pwm_drive),
      .o_chan_cfg(chan_cfg), .o_global_cfg(glob), .o_slew(), .o_olon_mode(), .o_delay_eff(),
      .o_out_on(), .o_sense_src(), .o_pwm_clk(), .o_cal_pulse(cal), .o_msg_rejected(rej));

   mcu_link_model i_mcu_link_model (.o_sclk(sclk), .o_cs_n(cs_n), .o_si(si));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic exp_t apply(input exp_t e, input logic [4:0] a, input logic [8:0] d,
                                  input int n);
      chan_cfg_t k;
      k = e.cfg[a[4:3]];
      e.rej = (n % 16 != 0) || (n == 0);
      e.cal = !e.rej && a == 5'h07;
      if (e.rej) return e;
      case (a[2:0])
         3'h2: {k.dir_dis, k.slew, k.delay} = d[5:0];
         3'h3: {k.retry_unlimited, k.retry_dis, k.os_dis, k.olon_dis, k.oloff_dis, k.olled,
                k.ratio_high} = d[6:0];
         3'h4: {k.cooling, k.inrush, k.alt_high, k.steady, k.oc_mode} = d[7:0];
         3'h5: if (a[4:3] == 2'b00) begin
            {e.g.vdd_fail_en, e.g.pwm_en, e.g.clock_sel, e.g.temp_en, e.g.current_feedback_enable,
             e.g.analog_sense_pin_sel, e.g.overvoltage_protect_disable} = {d[8:2], d[0]};
         end
         default: ;
      endcase
      e.cfg[a[4:3]] = k;
      return e;
   endfunction

   task automatic check(input string what, input exp_t got, input exp_t exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Toggling bit 0 makes any register write visible; frames with no visible effect push no note
   task automatic wr(input logic [4:0] a, input logic [8:0] d, input int n);
      exp_t       e;
      logic [8:0] dd;
      dd = d;
      e = apply(cur, a, dd, n);
      if ({e.cfg, e.g} == {cur.cfg, cur.g}) begin
         dd = d ^ 9'h001;
         e = apply(cur, a, dd, n);
      end
      if (e.rej || e.cal || {e.cfg, e.g} != {cur.cfg, cur.g}) notes.push_back(e);
      cur = e;
      i_mcu_link_model.send({rnd[15:0], 1'b0, a, 1'b0, dd}, n);
   endtask

   task automatic finish_test();
      if (notes.size() != 0) n_errors++;
      if (n_errors == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end

   always @(posedge i_clk) begin
      rnd <= lfsr(rnd);
      direct_in <= rnd[3:0];
      on_bit <= rnd[7:4];
      pwm_drive <= rnd[11:8];
   end

   always @(negedge i_clk) begin
      seen = {chan_cfg, glob, rej, cal};
      if (i_resetn && ({seen.cfg, seen.g} !== {prev.cfg, prev.g} || rej || cal)) begin
         if (notes.size() == 0) check("unexpected update", seen, prev);
         else check("register bank", seen, notes.pop_front());
      end
      prev = seen;
   end

   initial begin
      #200_000;
      n_errors++;
      finish_test();
   end

   initial begin
      logic [8:0] d;
      i_resetn = 1'b0;
      repeat (3) @(posedge i_clk);
      i_resetn <= 1'b1;
      @(negedge i_clk);
      check("reset values", {chan_cfg, glob, rej, cal}, '0);
      repeat (3) @(posedge i_clk);
      for (int c = 0; c < 4; c++) begin
         for (int r = 2; r < 5; r++) begin
            d = rnd[8:0];
            if (d[4:3] == 2'b11) d[4] = 1'b0;  // Unused slew code kept out
            wr({c[1:0], r[2:0]}, d, 16);
         end
      end
      for (int i = 0; i < 3; i++) wr(5'h0A, {4'h0, i[1:0], 3'h5}, 16);
      for (int i = 0; i < 4; i++) wr(5'h13, {5'h00, i[1], 1'b0, i[0], 1'b0}, 16);
      for (int i = 0; i < 16; i++) wr(5'h05, {rnd[8], i[3:0], rnd[3:0]}, 16);
      wr(5'h1D, rnd[8:0], 16);
      wr(5'h01, rnd[8:0], 16);
      wr(5'h07, 9'h11B, 16);
      wr(5'h0C, rnd[8:0], 0);
      wr(5'h0C, rnd[8:0], 15);
      wr(5'h0C, rnd[8:0], 17);
      wr(5'h0C, rnd[8:0], 32);
      repeat (20) @(posedge i_clk);
      finish_test();
   end
endmodule // output_config_register_bank_test

bind output_config_register_bank output_config_register_bank_monitor
   i_output_config_register_bank_monitor (
   .i_clk(i_clk), .i_resetn(i_resetn), .i_pwm_drive(i_pwm_drive), .i_direct_in(i_direct_in),
   .i_on_bit(i_on_bit), .o_chan_cfg(o_chan_cfg),
   .o_global_cfg(o_global_cfg), .o_slew(o_slew), .o_olon_mode(o_olon_mode),
   .o_delay_eff(o_delay_eff), .o_out_on(o_out_on), .o_sense_src(o_sense_src),
   .o_pwm_clk(o_pwm_clk), .o_cal_pulse(o_cal_pulse), .o_msg_rejected(o_msg_rejected));

`default_nettype wire
